// [design/cmpone_cfg.svh]
// Register offsets, field positions and reset values of the comparator control block
`ifndef CMPONE_CFG_SVH
`define CMPONE_CFG_SVH
`define CMPONE_ADDR_INPUT_SEL 8'hAA
`define CMPONE_ADDR_MODE 8'hAB
`define CMPONE_ADDR_CTRL 8'hBF
`define CMPONE_RST_INPUT_SEL 8'hFF
`define CMPONE_RST_MODE 8'h02
`define CMPONE_RST_CTRL 8'h00
`define CMPONE_BIT_ON 7
`define CMPONE_BIT_LIVE 6
`define CMPONE_BIT_RISE 5
`define CMPONE_BIT_FALL 4
`define CMPONE_POS_HYSP 2
`define CMPONE_POS_HYSN 0
`define CMPONE_BIT_LATCH 7
`define CMPONE_BIT_RISE_EN 5
`define CMPONE_BIT_FALL_EN 4
`define CMPONE_POS_SPEED 0
`define CMPONE_POS_MINUS 4
`define CMPONE_POS_PLUS 0
`endif

// [design/cmpone_pkg.sv]
// Types shared by the comparator control block
package cmpone_pkg;
   typedef enum logic [1:0] {
      CMPONE_HYS_OFF = 2'h0,
      CMPONE_HYS_5MV = 2'h1,
      CMPONE_HYS_10MV = 2'h2,
      CMPONE_HYS_20MV = 2'h3
   } cmpone_hys_t;
   typedef struct packed {
      logic on;
      cmpone_hys_t hys_pos;
      cmpone_hys_t hys_neg;
      logic [1:0] speed;
      logic [3:0] minus_sel;
      logic [3:0] plus_sel;
   } cmpone_analog_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cmpone_sfr_req_t;
endpackage

// [design/cmpone_edge.sv]
// Synchroniser and edge detector for the comparator output
`timescale 1ns/1ps
module cmpone_edge
   import cmpone_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic raw_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic sync_a;
   logic sync_b;
   logic prev;
   assign level = sync_b;
   assign rise = sync_b & ~prev;
   assign fall = ~sync_b & prev;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         sync_a <= raw_in;
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end
endmodule

// [design/cmpone_regs.sv]
// Comparator one control, status, mode and input select registers
`timescale 1ns/1ps
`include "cmpone_cfg.svh"
module cmpone_regs
   import cmpone_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire cmpone_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic cmp_raw_out,
   input wire logic counter_array_overflow,
   output cmpone_analog_t analog_ctrl,
   output logic cmp_irq
);
   // -------------------------------------------
   // Stored state
   // -------------------------------------------
   logic cmp_on;
   logic cmp_live_level;
   logic rise_seen_flag;
   logic fall_seen_flag;
   cmpone_hys_t pos_hysteresis_sel;
   cmpone_hys_t neg_hysteresis_sel;
   logic overflow_sampled_level;
   logic rise_irq_en;
   logic fall_irq_en;
   logic [1:0] response_speed_sel;
   logic [3:0] minus_input_sel;
   logic [3:0] plus_input_sel;
   logic ovf_sync_a;
   logic ovf_sync_b;
   logic ovf_prev;
   // -------------------------------------------
   // Edge detection
   // -------------------------------------------
   logic live_level;
   logic live_rise;
   logic live_fall;
   cmpone_edge u_edge (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .raw_in(cmp_raw_out),
      .level(live_level),
      .rise(live_rise),
      .fall(live_fall)
   );
   // -------------------------------------------
   // Decode
   // -------------------------------------------
   wire wr_ctrl = sfr_req.wr && (sfr_req.addr == `CMPONE_ADDR_CTRL);
   wire wr_mode = sfr_req.wr && (sfr_req.addr == `CMPONE_ADDR_MODE);
   wire wr_sel = sfr_req.wr && (sfr_req.addr == `CMPONE_ADDR_INPUT_SEL);
   wire [7:0] wd = sfr_req.wdata;
   wire ovf_pulse = ovf_sync_b & ~ovf_prev;
   // Reset images of the mode and select registers
   localparam logic [7:0] mode_rst = `CMPONE_RST_MODE;
   localparam logic [7:0] sel_rst = `CMPONE_RST_INPUT_SEL;
   // Set beats a simultaneous software clear
   wire next_rise = live_rise | (wr_ctrl ? wd[`CMPONE_BIT_RISE] : rise_seen_flag);
   wire next_fall = live_fall | (wr_ctrl ? wd[`CMPONE_BIT_FALL] : fall_seen_flag);
   // Only the edge enable gates; reads of the flags are unaffected
   wire next_irq = (rise_seen_flag & rise_irq_en) | (fall_seen_flag & fall_irq_en);
   wire [7:0] ctrl_view = {cmp_on, cmp_live_level, rise_seen_flag, fall_seen_flag,
                           pos_hysteresis_sel, neg_hysteresis_sel};
   // Reserved mode bits read zero whatever software writes
   wire [7:0] mode_view = {overflow_sampled_level, 1'b0, rise_irq_en, fall_irq_en,
                           2'b00, response_speed_sel};
   wire [7:0] sel_view = {minus_input_sel, plus_input_sel};
   wire [7:0] next_rdata = (sfr_req.addr == `CMPONE_ADDR_CTRL) ? ctrl_view :
                           (sfr_req.addr == `CMPONE_ADDR_MODE) ? mode_view :
                           (sfr_req.addr == `CMPONE_ADDR_INPUT_SEL) ? sel_view : 8'h00;
   // -------------------------------------------
   // Analog core drive
   // -------------------------------------------
   // One driver for the whole struct keeps strict tools quiet
   cmpone_analog_t next_analog;
   assign next_analog = '{
      on: cmp_on,
      hys_pos: pos_hysteresis_sel,
      hys_neg: neg_hysteresis_sel,
      speed: response_speed_sel,
      minus_sel: minus_input_sel,
      plus_sel: plus_input_sel
   };
   // -------------------------------------------
   // Registers
   // -------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cmp_on <= 1'b0;
         pos_hysteresis_sel <= CMPONE_HYS_OFF;
         neg_hysteresis_sel <= CMPONE_HYS_OFF;
         rise_seen_flag <= 1'b0;
         fall_seen_flag <= 1'b0;
      end
      else
      begin
         rise_seen_flag <= next_rise;
         fall_seen_flag <= next_fall;
         if (wr_ctrl)
         begin
            cmp_on <= wd[`CMPONE_BIT_ON];
            pos_hysteresis_sel <= cmpone_hys_t'(wd[`CMPONE_POS_HYSP +: 2]);
            neg_hysteresis_sel <= cmpone_hys_t'(wd[`CMPONE_POS_HYSN +: 2]);
         end
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rise_irq_en <= 1'b0;
         fall_irq_en <= 1'b0;
         response_speed_sel <= mode_rst[`CMPONE_POS_SPEED +: 2];
      end
      else if (wr_mode)
      begin
         rise_irq_en <= wd[`CMPONE_BIT_RISE_EN];
         fall_irq_en <= wd[`CMPONE_BIT_FALL_EN];
         response_speed_sel <= wd[`CMPONE_POS_SPEED +: 2];
      end
   end
   // Reserved codes are stored and passed on; the core decides
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         minus_input_sel <= sel_rst[`CMPONE_POS_MINUS +: 4];
         plus_input_sel <= sel_rst[`CMPONE_POS_PLUS +: 4];
      end
      else if (wr_sel)
      begin
         minus_input_sel <= wd[`CMPONE_POS_MINUS +: 4];
         plus_input_sel <= wd[`CMPONE_POS_PLUS +: 4];
      end
   end
   // Overflow may come from another timer domain, so synchronise it
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ovf_sync_a <= 1'b0;
         ovf_sync_b <= 1'b0;
         ovf_prev <= 1'b0;
         overflow_sampled_level <= 1'b0;
      end
      else
      begin
         ovf_sync_a <= counter_array_overflow;
         ovf_sync_b <= ovf_sync_a;
         ovf_prev <= ovf_sync_b;
         if (ovf_pulse)
         begin
            overflow_sampled_level <= live_level;
         end
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cmp_live_level <= 1'b0;
         cmp_irq <= 1'b0;
         sfr_rdata <= 8'h00;
         analog_ctrl <= '0;
      end
      else
      begin
         cmp_live_level <= live_level;
         cmp_irq <= next_irq;
         sfr_rdata <= next_rdata;
         analog_ctrl <= next_analog;
      end
   end
endmodule

// [verification/cmpone_far.sv]
// Analog comparator and overflow source model
`timescale 1ns/1ps
module cmpone_far
(
   input wire logic ref_clk,
   input wire logic lvl,
   input wire logic tick,
   output logic cmp_raw_out,
   output logic counter_array_overflow
);
   logic [2:0] n = 3'h0;
   initial cmp_raw_out = 1'b0;
   // Lag like a real analog stage, off the clock grid
   always @(lvl) cmp_raw_out <= #3 lvl;
   // Held 4 cycles, the synchroniser needs at least 2
   always @(posedge ref_clk) n <= tick ? 3'h4 : n - {2'h0, n != 3'h0};
   assign counter_array_overflow = n != 3'h0;
endmodule

// [verification/cmpone_regs_sva.sv]
// Checker for the comparator one control registers
`timescale 1ns/1ps
module cmpone_chk
   import cmpone_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire cmpone_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic cmp_raw_out,
   input wire logic counter_array_overflow,
   input wire cmpone_analog_t analog_ctrl,
   input wire logic cmp_irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire wc = sfr_req.wr && sfr_req.addr == 8'hBF;
   wire wm = sfr_req.wr && sfr_req.addr == 8'hAB;
   wire ws = sfr_req.wr && sfr_req.addr == 8'hAA;
   wire [7:0] d = sfr_req.wdata;
   a_on_bit: assert property (wc |-> ##2 analog_ctrl.on == $past(d[7], 2))
      else $error("enable wrong");
   a_hys_pos: assert property (wc |=> ##1 analog_ctrl.hys_pos == $past(d[3:2], 2))
      else $error("hys pos wrong");
   a_hys_neg: assert property (wc ##2 1 |-> analog_ctrl.hys_neg == $past(d[1:0], 2))
      else $error("hys neg wrong");
   a_speed_sel: assert property (wm |-> ##2 analog_ctrl.speed == $past(d[1:0], 2))
      else $error("speed wrong");
   a_mux_sel: assert property (
      ws |-> ##2 {analog_ctrl.minus_sel, analog_ctrl.plus_sel} == $past(d, 2))
      else $error("mux wrong");
   a_live_level: assert property (
      $stable(cmp_raw_out) [*5] ##0 sfr_req.addr == 8'hBF |=> sfr_rdata[6] == $past(cmp_raw_out))
      else $error("live bit wrong");
   a_flag_sticky: assert property (
      sfr_req.addr == 8'hBF && !sfr_req.wr ##1 sfr_req.addr == 8'hBF
      |=> (sfr_rdata[5:4] & $past(sfr_rdata[5:4])) == $past(sfr_rdata[5:4]))
      else $error("flag lost");
   a_irq_masked: assert property (wm && d[5:4] == 2'h0 ##1 !wm |=> !cmp_irq)
      else $error("irq not masked");
   cover property (cmp_irq);
   cover property ($rose(counter_array_overflow));
   cover property (wc && d[5]);
endmodule
bind cmpone_regs cmpone_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .cmp_raw_out(cmp_raw_out), .analog_ctrl(analog_ctrl),
   .counter_array_overflow(counter_array_overflow), .cmp_irq(cmp_irq));

// [verification/cmpone_regs_test.sv]
// Self-checking bench for the comparator one control registers
`timescale 1ns/1ps
module cmpone_regs_test
   import cmpone_pkg::*;
;
   logic ref_clk, sys_rst = 1'b1, lvl = 1'b0, tick = 1'b0, rv = 1'b0;
   logic cmp_raw_out, counter_array_overflow, cmp_irq;
   cmpone_sfr_req_t sfr_req = '0;
   cmpone_analog_t analog_ctrl;
   logic [7:0] sfr_rdata;
   // Analog drive folded into bytes for the check task
   wire [7:0] ana_cfg = {analog_ctrl.on, analog_ctrl.hys_pos, analog_ctrl.hys_neg, 1'b0,
                         analog_ctrl.speed};
   wire [7:0] ana_sel = {analog_ctrl.minus_sel, analog_ctrl.plus_sel};
   logic [7:0] q[$];
   logic [31:0] d;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   integer seed = 32'hC4827067;
   cmpone_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .cmp_raw_out(cmp_raw_out), .analog_ctrl(analog_ctrl),
      .counter_array_overflow(counter_array_overflow), .cmp_irq(cmp_irq));
   cmpone_far far (.ref_clk(ref_clk), .lvl(lvl), .tick(tick), .cmp_raw_out(cmp_raw_out),
      .counter_array_overflow(counter_array_overflow));
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Read data is due one cycle later, so only the note is queued
   task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
      sfr_req <= '{w, !w, a, v};
      if (!w) q.push_back(v);
      @(posedge ref_clk);
   endtask
   task automatic idle(int n);
      sfr_req <= '0;
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic ovf;
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
      idle(10);
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      if (rv === 1'b1) chk(sfr_rdata, q.pop_front());
      rv <= sfr_req.rd;
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   // ---------------
   // Main sequence
   // ---------------
   initial
   begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      acc(0, 8'hBF, 8'h00);
      acc(0, 8'hAB, 8'h02);
      acc(0, 8'hAA, 8'hFF);
      acc(1, 8'h00, 8'h55);
      acc(0, 8'h00, 8'h00);
      chk(ana_cfg, 8'h02);
      chk(ana_sel, 8'hFF);
      for (int i = 0; i < 4; i++)
      begin
         acc(1, 8'hAB, 8'(i));
         acc(0, 8'hAB, 8'(i));
         acc(1, 8'hBF, {4'h8, 2'(i), 2'(3 - i)});
         acc(0, 8'hBF, {4'h8, 2'(i), 2'(3 - i)});
         idle(1);
         chk(ana_cfg, {1'b1, 2'(i), 2'(3 - i), 1'b0, 2'(i)});
      end
      lvl <= 1'b1;
      idle(8);
      acc(0, 8'hBF, 8'hEC);
      acc(1, 8'hBF, 8'h8C);
      acc(0, 8'hBF, 8'hCC);
      lvl <= 1'b0;
      idle(8);
      acc(0, 8'hBF, 8'h9C);
      acc(1, 8'hAB, 8'h13);
      idle(3);
      chk({7'h0, cmp_irq}, 8'h01);
      acc(1, 8'hAB, 8'h23);
      idle(3);
      chk({7'h0, cmp_irq}, 8'h00);
      acc(1, 8'hBF, 8'hAC);
      idle(3);
      chk({7'h0, cmp_irq}, 8'h01);
      acc(1, 8'hBF, 8'h8C);
      idle(3);
      chk({7'h0, cmp_irq}, 8'h00);
      lvl <= 1'b1;
      idle(8);
      ovf;
      acc(0, 8'hAB, 8'hA3);
      lvl <= 1'b0;
      idle(8);
      ovf;
      acc(0, 8'hAB, 8'h23);
      for (int i = 0; i < 4; i++)
      begin
         d = $random(seed);
         acc(1, 8'hAA, d[7:0]);
         acc(0, 8'hAA, d[7:0]);
         idle(1);
         chk(ana_sel, d[7:0]);
      end
      idle(3);
      report_and_stop;
   end
endmodule
